//--- hw/smist_pkg.sv
// package: register offsets, field layout and timing constants for the smi status block
package smist_pkg;
	// configuration offsets (byte addresses in function 0 space)
	localparam logic [7:0] SMIST_OFS_STATUS = 8'haa; // status word, low byte
	localparam logic [7:0] SMIST_OFS_STATUS_HI = 8'hab; // status word, high byte
	localparam logic [7:0] SMIST_OFS_LOW_TIME = 8'hac; // asserted phase length
	localparam logic [7:0] SMIST_OFS_HIGH_TIME = 8'hae; // negated phase length
	// reset values
	localparam logic [7:0] SMIST_RST_TIME = 8'h00;
	localparam logic [15:0] SMIST_RST_STATUS = 16'h0000;
	// status bit positions
	localparam int SMIST_BIT_USB = 8;
	localparam int SMIST_BIT_APM = 7;
	localparam int SMIST_BIT_EXT = 6;
	localparam int SMIST_BIT_IDLE = 5;
	localparam int SMIST_NUM_IRQ = 5; // bits 4..0: irq12, irq8, irq4, irq3, irq1
	localparam logic [15:0] SMIST_IMPL_MASK = 16'h01ff; // bits 15:9 reserved
	// phase length: 1 + 1056 * (value + 1) clocks
	localparam logic [19:0] SMIST_PHASE_MULT = 20'h0_0420; // 1056
	localparam logic [19:0] SMIST_PHASE_BASE = 20'h0_0001;
	// event sources travelling together
	typedef struct packed {
		logic usb_keyboard; // legacy keyboard emulation request
		logic power_ctl_write; // power control register written
		logic external_pin; // external request pin active
		logic idle_timer; // idle timer expiry pulse
		logic [4:0] irq; // irq12, irq8, irq4, irq3, irq1 levels
	} smist_src_t;
	// throttle phase state
	typedef enum logic [1:0] {
		SMIST_IDLE = 2'b00,
		SMIST_HALT = 2'b01,
		SMIST_RUN = 2'b10
	} smist_state_t;
endpackage : smist_pkg

//--- hw/smist_top.sv
// module: smi cause status register and stop-clock throttle timer
`timescale 1ns/1ns
`default_nettype none
// Function
// - each status bit independent of others, gate
// - hardware set beats simultaneous software clear
// - one status indication per event activation
// - interrupt lines detected on asserting edge
// - irq status stays set after line negates
// - bit 8 records usb keyboard emulation smi
// - bit 7 records power control write smi
// - bit 6 records external pin smi
// - bit 5 records idle timer expiry smi
// - bits 4..0 record irq 12,8,4,3,1
// - writing zero clears; bits 15:9 reserved
// - load low time on stop-clock assert
// - load high time on stop-clock negate
// - phase lasts 1 + 1056*(value+1) clocks
// - only enabled sources are recorded
// - idle timer expiry raises smi; here it only sets status bit 5, no smi output
module smist_top (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// configuration access, byte wide
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [7:0] cfg_addr,
	input wire logic [7:0] cfg_wdata,
	output logic [7:0] cfg_rdata,
	// event sources and their enables
	input wire smist_pkg::smist_src_t src,
	input wire logic [8:0] src_enable,
	// throttle enable, control bit 2
	input wire logic throttle_en,
	// outputs to processor
	output logic cpu_halt_clock_n,
	output logic [15:0] smi_cause_status
);
	import smist_pkg::*;

	// source flat vector, bit positions match status bits
	logic [8:0] src_vec;
	logic [8:0] src_prev; // last sampled level for edge detect
	logic [8:0] next_src_prev;
	logic [8:0] src_edge; // one-cycle activation, gated by enable
	logic [15:0] next_status;
	logic [7:0] throttle_low_time;
	logic [7:0] throttle_high_time;
	logic [7:0] next_low;
	logic [7:0] next_high;
	logic [7:0] next_rdata;
	logic [7:0] wr_lo_byte; // write data aligned to low status byte
	logic wr_lo; // low status byte written
	logic wr_hi; // high status byte written
	smist_state_t state, next_state;
	logic [19:0] phase_cnt, next_phase_cnt;
	logic next_halt_n;

	assign src_vec = {src.usb_keyboard, src.power_ctl_write, src.external_pin,
		src.idle_timer, src.irq};

	// event edge detection; a held event yields a single set pulse
	always_comb begin
		next_src_prev = src_vec;
		src_edge = src_vec & ~src_prev & src_enable;
	end

	// status bits: write-zero clears, edge sets, set wins
	always_comb begin
		wr_lo = cfg_wr && (cfg_addr == SMIST_OFS_STATUS);
		wr_hi = cfg_wr && (cfg_addr == SMIST_OFS_STATUS_HI);
		wr_lo_byte = cfg_wdata;
		next_status = smi_cause_status;
		if (wr_lo) begin
			next_status[7:0] = smi_cause_status[7:0] & wr_lo_byte;
		end
		if (wr_hi) begin
			next_status[15:8] = smi_cause_status[15:8] & cfg_wdata;
		end
		// per-bit set, no cross-bit coupling, no gate dependence
		next_status[8:0] = next_status[8:0] | src_edge;
		next_status = next_status & SMIST_IMPL_MASK;
	end

	// timer registers and read mux
	always_comb begin
		next_low = throttle_low_time;
		next_high = throttle_high_time;
		if (cfg_wr && cfg_addr == SMIST_OFS_LOW_TIME) begin
			next_low = cfg_wdata;
		end
		if (cfg_wr && cfg_addr == SMIST_OFS_HIGH_TIME) begin
			next_high = cfg_wdata;
		end
		case (cfg_addr)
			SMIST_OFS_STATUS: next_rdata = smi_cause_status[7:0];
			SMIST_OFS_STATUS_HI: next_rdata = smi_cause_status[15:8];
			SMIST_OFS_LOW_TIME: next_rdata = throttle_low_time;
			SMIST_OFS_HIGH_TIME: next_rdata = throttle_high_time;
			default: next_rdata = 8'h00; // unmapped reads zero
		endcase
		if (!cfg_rd) begin
			next_rdata = cfg_rdata; // hold last read value
		end
	end

	// throttle state machine; phase_cnt counts down the current phase
	always_comb begin
		next_state = state;
		next_phase_cnt = phase_cnt;
		next_halt_n = cpu_halt_clock_n;
		case (state)
			SMIST_IDLE: begin
				next_halt_n = 1'b1;
				if (throttle_en) begin
					next_state = SMIST_HALT;
					next_halt_n = 1'b0;
					// length 1+1056*(v+1); counter holds length-1
					next_phase_cnt = SMIST_PHASE_MULT * ({12'h000, throttle_low_time}
						+ 20'h0_0001);
				end
			end
			SMIST_HALT: begin
				if (!throttle_en) begin
					next_state = SMIST_IDLE;
					next_halt_n = 1'b1;
				end else if (phase_cnt == 20'h0_0000) begin
					next_state = SMIST_RUN;
					next_halt_n = 1'b1;
					next_phase_cnt = SMIST_PHASE_MULT * ({12'h000, throttle_high_time}
						+ 20'h0_0001);
				end else begin
					next_phase_cnt = phase_cnt - 20'h0_0001;
				end
			end
			SMIST_RUN: begin
				if (!throttle_en) begin
					next_state = SMIST_IDLE;
				end else if (phase_cnt == 20'h0_0000) begin
					next_state = SMIST_HALT;
					next_halt_n = 1'b0;
					next_phase_cnt = SMIST_PHASE_MULT * ({12'h000, throttle_low_time}
						+ 20'h0_0001);
				end else begin
					next_phase_cnt = phase_cnt - 20'h0_0001;
				end
			end
			default: begin
				next_state = SMIST_IDLE;
				next_halt_n = 1'b1;
			end
		endcase
	end

	// all state registered here; stop-clock negated (high) at reset
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			src_prev <= 9'h000;
			smi_cause_status <= SMIST_RST_STATUS;
			throttle_low_time <= SMIST_RST_TIME;
			throttle_high_time <= SMIST_RST_TIME;
			cfg_rdata <= 8'h00;
			state <= SMIST_IDLE;
			phase_cnt <= 20'h0_0000;
			cpu_halt_clock_n <= 1'b1;
		end else begin
			src_prev <= next_src_prev;
			smi_cause_status <= next_status;
			throttle_low_time <= next_low;
			throttle_high_time <= next_high;
			cfg_rdata <= next_rdata;
			state <= next_state;
			phase_cnt <= next_phase_cnt;
			cpu_halt_clock_n <= next_halt_n;
		end
	end

	// checks on the logic above
	sequence s_enter_halt;
		$fell(cpu_halt_clock_n) && throttle_en;
	endsequence

	// negated phase entered from the asserted one, not a drop to idle
	sequence s_enter_run;
		$rose(cpu_halt_clock_n) && (state == SMIST_RUN);
	endsequence

	AST_SET_WINS: assert property (@(posedge mclk) disable iff (!rst_n)
		(src_edge[1] && wr_lo && !cfg_wdata[1]) |=> smi_cause_status[1])
		else $error("set lost to simultaneous clear");
	AST_EDGE_ONLY: assert property (@(posedge mclk) disable iff (!rst_n)
		(wr_lo && !cfg_wdata[1] && src_prev[1] && src.irq[1]) |=> !smi_cause_status[1])
		else $error("held event set bit again");
	AST_IRQ_SET: assert property (@(posedge mclk) disable iff (!rst_n)
		(src_enable[4] && src.irq[4] && !src_prev[4]) |=> smi_cause_status[4])
		else $error("irq edge not recorded");
	AST_STICKY: assert property (@(posedge mclk) disable iff (!rst_n)
		(smi_cause_status[2] && !(wr_lo && !cfg_wdata[2])) |=> smi_cause_status[2])
		else $error("status bit dropped without clear");
	AST_RESERVED: assert property (@(posedge mclk) disable iff (!rst_n)
		smi_cause_status[15:9] == 7'h00)
		else $error("reserved status bits set");
	AST_ENABLE: assert property (@(posedge mclk) disable iff (!rst_n)
		(!src_enable[0] && !smi_cause_status[0] && !(cfg_wr)) |=> !smi_cause_status[0])
		else $error("disabled source recorded");
	AST_LOW_LOAD: assert property (@(posedge mclk) disable iff (!rst_n)
		s_enter_halt |-> phase_cnt == SMIST_PHASE_MULT * ({12'h000, $past(throttle_low_time)}
			+ 20'h0_0001))
		else $error("low time not loaded");
	AST_HIGH_LOAD: assert property (@(posedge mclk) disable iff (!rst_n)
		s_enter_run |-> phase_cnt == SMIST_PHASE_MULT * ({12'h000, $past(throttle_high_time)}
			+ 20'h0_0001))
		else $error("high time not loaded");
	AST_ALTERNATE: assert property (@(posedge mclk) disable iff (!rst_n)
		(state == SMIST_HALT && throttle_en && phase_cnt == 20'h0_0000)
			|=> (state == SMIST_RUN && cpu_halt_clock_n))
		else $error("phase did not alternate");
	AST_MIN_PHASE: assert property (@(posedge mclk) disable iff (!rst_n)
		s_enter_halt ##1 throttle_en[*8] |-> !cpu_halt_clock_n)
		else $error("asserted phase too short");
endmodule : smist_top
`default_nettype wire

//--- dv/smist_cpu_model.sv
// cpu side model: times the stop-clock phases it receives
`timescale 1ns/1ns
`default_nettype none
module smist_cpu_model (
	// clock and pin from block
	input wire logic mclk,
	input wire logic cpu_halt_clock_n,
	// last measured phase lengths
	output int low_len,
	output int high_len
);
	int cnt = 1; // samples since last pin change
	logic last = 1'b1; // level seen at previous edge
	// latch each phase length as the pin turns
	always @(posedge mclk) begin
		if (cpu_halt_clock_n !== last) begin
			if (last) high_len <= cnt;
			else low_len <= cnt;
			cnt <= 1;
			last <= cpu_halt_clock_n;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule : smist_cpu_model
`default_nettype wire

//--- dv/smist_top_tb_top.sv
// testbench: status register, events and throttle timing
`timescale 1ns/1ns
`default_nettype none
module smist_top_tb_top;
	import smist_pkg::*;
	logic mclk = 1'b0; // 20 MHz
	logic rst_n = 1'b0;
	logic cfg_wr = 1'b0;
	logic cfg_rd = 1'b0;
	logic [7:0] cfg_addr = 8'h00;
	logic [7:0] cfg_wdata = 8'h00;
	logic [7:0] cfg_rdata;
	smist_src_t src = smist_src_t'(9'h000);
	logic [8:0] src_enable = 9'h1ff; // all nine sources enabled
	logic throttle_en = 1'b0;
	logic cpu_halt_clock_n;
	logic [15:0] smi_cause_status;
	logic [7:0] rd; // last byte read
	int low_len, high_len; // measured phases
	int miscompares = 0;
	int compares = 0;
	always #25 mclk = ~mclk;
	smist_top DUT (.mclk(mclk), .rst_n(rst_n), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
		.cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .src(src),
		.src_enable(src_enable), .throttle_en(throttle_en),
		.cpu_halt_clock_n(cpu_halt_clock_n), .smi_cause_status(smi_cause_status));
	smist_cpu_model cpu (.mclk(mclk), .cpu_halt_clock_n(cpu_halt_clock_n),
		.low_len(low_len), .high_len(high_len));
	// one counted comparison
	task automatic chk(input string w, input logic [15:0] s, input logic [15:0] e);
		compares++;
		if (s !== e) begin
			miscompares++;
			$display("MISMATCH %s exp %h seen %h", w, e, s);
		end
	endtask : chk
	// one byte write, strobe for one cycle
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk);
		cfg_wr = 1'b1;
		cfg_addr = a;
		cfg_wdata = d;
		@(negedge mclk);
		cfg_wr = 1'b0;
	endtask : wr
	// one byte read, data registered at the taking edge
	task automatic rdb(input logic [7:0] a);
		@(negedge mclk);
		cfg_rd = 1'b1;
		cfg_addr = a;
		@(negedge mclk);
		cfg_rd = 1'b0;
		rd = cfg_rdata;
	endtask : rdb
	task automatic end_sim;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (compares > 0 && miscompares == 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_sim
	// reset values, read back, unmapped byte
	task automatic t_regs;
		chk("pin", {15'h0000, cpu_halt_clock_n}, 16'h0001);
		chk("st", smi_cause_status, 16'h0000);
		rdb(SMIST_OFS_HIGH_TIME);
		chk("hi", {8'h00, rd}, 16'h0000);
		wr(SMIST_OFS_LOW_TIME, 8'ha5);
		wr(8'had, 8'hff);
		rdb(SMIST_OFS_LOW_TIME);
		chk("lo", {8'h00, rd}, 16'h00a5);
		rdb(8'had);
		chk("unmap", {8'h00, rd}, 16'h0000);
		$display("t_regs done");
	endtask : t_regs
	// every source: edge sets, stays after negate, one set per activation
	task automatic t_events;
		for (int i = 0; i < 9; i++) begin
			@(negedge mclk);
			src = smist_src_t'(9'h001 << i);
			@(negedge mclk);
			chk("set", smi_cause_status, 16'h0001 << i);
			src = smist_src_t'(9'h000);
			@(negedge mclk);
			chk("kept", smi_cause_status, 16'h0001 << i);
			src = smist_src_t'(9'h001 << i);
			wr(SMIST_OFS_STATUS, 8'h00);
			wr(SMIST_OFS_STATUS_HI, 8'h00);
			chk("once", smi_cause_status, 16'h0000);
			src = smist_src_t'(9'h000);
		end
		$display("t_events done");
	endtask : t_events
	// disabled source, set against clear, independent and reserved bits
	task automatic t_mix;
		@(negedge mclk);
		src_enable = 9'h1fe;
		src = smist_src_t'(9'h001);
		@(negedge mclk);
		chk("dis", smi_cause_status, 16'h0000);
		src_enable = 9'h1ff;
		src = smist_src_t'(9'h003);
		cfg_wr = 1'b1;
		cfg_addr = SMIST_OFS_STATUS;
		cfg_wdata = 8'h00;
		@(negedge mclk);
		cfg_wr = 1'b0;
		chk("race", smi_cause_status, 16'h0002);
		src = smist_src_t'(9'h007);
		wr(SMIST_OFS_STATUS, 8'h02);
		chk("indep", smi_cause_status, 16'h0002);
		rdb(SMIST_OFS_STATUS);
		chk("rdlo", {8'h00, rd}, 16'h0002);
		wr(SMIST_OFS_STATUS_HI, 8'hff);
		rdb(SMIST_OFS_STATUS_HI);
		chk("resv", {8'h00, rd}, 16'h0000);
		src = smist_src_t'(9'h000);
		$display("t_mix done");
	endtask : t_mix
	// throttle phases measured by the cpu model
	task automatic t_throttle;
		wr(SMIST_OFS_LOW_TIME, 8'h00);
		wr(SMIST_OFS_HIGH_TIME, 8'h01);
		throttle_en = 1'b1;
		repeat (3500) @(negedge mclk);
		chk("lolen", 16'(low_len), 16'h0421);
		chk("hilen", 16'(high_len), 16'h0841);
		throttle_en = 1'b0;
		repeat (2) @(negedge mclk);
		chk("stop", {15'h0000, cpu_halt_clock_n}, 16'h0001);
		$display("t_throttle done");
	endtask : t_throttle
	initial begin
		repeat (12) @(negedge mclk);
		rst_n = 1'b1;
		t_regs();
		t_events();
		t_mix();
		t_throttle();
		end_sim();
	end
	// watchdog: about twice the expected run
	initial begin
		#400_000;
		miscompares++;
		end_sim();
	end
endmodule : smist_top_tb_top
`default_nettype wire
